//--- design/las_top.sv
// Purpose: link-analysis diagnostic status register with pair mapping
// Assumes: link status inputs come from the PHY core on mclk_i
// Notes: result register is hardware-owned; software writes ignored there
//
// Our own choice: the address-and-strobe port.
`include "las_params.svh"
module las_top
    import las_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [4:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // link status from core
    input wire logic link_up_i,
    input wire logic gig_i,
    input wire logic mdix_i,
    input wire logic cd_swap_det_i,
    input wire logic [3:0] pol_ok_i,
    input wire logic descr_lock_i,
    input wire logic [8:0] len_m_i,
    input wire logic len_ok_i,
    // pair mapping
    output logic [7:0] tx_pair_o,
    output logic [7:0] rx_pair_o,
    // interrupt
    output logic irq_o
);
    logic mode_link_q;
    logic [15:0] result_q;
    logic [15:0] result_d;
    logic [2:0] stat_q;
    logic [2:0] en_q;
    logic [2:0] evt;
    logic [5:0] len_code;
    logic link_q;
    las_state_type st_q;
    las_state_type st_d;

    las_len_code u_len (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .len_m_i(len_m_i),
        .len_ok_i(len_ok_i),
        .code_o(len_code)
    );

    las_pair_map u_map (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .mdix_i(mdix_i),
        .swap_i(result_q[`LAS_BIT_SWAP]),
        .tx_pair_o(tx_pair_o),
        .rx_pair_o(rx_pair_o)
    );

    // link state: which fields are meaningful
    always_comb begin
        case ({link_up_i, gig_i})
            2'b11: st_d = LAS_ST_GIG;
            2'b10: st_d = LAS_ST_LOW;
            default: st_d = LAS_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_q <= LAS_ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // gigabit-only bits held at zero otherwise so stale values never show
    always_comb begin
        result_d = `LAS_ZERO16; // RULE13
        case (st_q)
            LAS_ST_GIG: begin
                result_d[`LAS_BIT_SWAP] = cd_swap_det_i; // RULE1
                result_d[`LAS_LEN_HI:`LAS_LEN_LO] = len_code; // RULE2
                result_d[`LAS_POL_HI:`LAS_POL_LO] = pol_ok_i; // RULE6
                result_d[`LAS_BIT_SKEW] = ~descr_lock_i; // RULE7
            end
            LAS_ST_LOW: begin
                result_d[`LAS_LEN_HI:`LAS_LEN_LO] = len_code; // RULE2
            end
            default: begin
                result_d = `LAS_ZERO16;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            result_q <= `LAS_RESULT_RESET; // RULE13
        end else begin
            result_q <= result_d;
        end
    end

    // mode select: link analysis vs reflectometry
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mode_link_q <= `LAS_MODE_LINK;
        end else if (reg_wr_i && reg_addr_i == `LAS_OFS_MODE) begin
            mode_link_q <= reg_wdata_i[0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            link_q <= 1'b0;
        end else begin
            link_q <= link_up_i;
        end
    end

    assign evt[`LAS_EVT_RESULT] = result_d != result_q;
    assign evt[`LAS_EVT_SKEW] = result_d[`LAS_BIT_SKEW] & ~result_q[`LAS_BIT_SKEW];
    assign evt[`LAS_EVT_LINK] = link_up_i != link_q;

    // sticky status: set wins over clear
    genvar g;
    generate
        for (g = 0; g < `LAS_NUM_EVT; g++) begin : g_evt
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    stat_q[g] <= 1'b0;
                end else if (evt[g]) begin
                    stat_q[g] <= 1'b1;
                end else if (reg_wr_i && reg_addr_i == `LAS_OFS_IRQ_CLR && reg_wdata_i[g]) begin
                    stat_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            en_q <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == `LAS_OFS_IRQ_EN) begin
            en_q <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_q & en_q);
        end
    end

    // read data one cycle after strobe, zero otherwise
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= `LAS_ZERO16;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `LAS_OFS_RESULT: reg_rdata_o <= mode_link_q ? result_q : `LAS_ZERO16; // RULE12
                `LAS_OFS_MODE: reg_rdata_o <= {15'h0000, mode_link_q};
                `LAS_OFS_IRQ_STAT: reg_rdata_o <= {13'h0000, stat_q};
                `LAS_OFS_IRQ_EN: reg_rdata_o <= {13'h0000, en_q};
                default: reg_rdata_o <= `LAS_ZERO16;
            endcase
        end else begin
            reg_rdata_o <= `LAS_ZERO16;
        end
    end
endmodule

//--- design/las_params.svh
// Purpose: constants for the link-analysis status block
// Assumes: one 16-bit result register plus interrupt registers on a plain port
// Notes: values only, no logic
// Contract
// RULE1: swap bit set when pairs C/D exchanged
// RULE2: six-bit length field at bits 10:5
// RULE3: codes 0..31 mean 0..155 m, 5 m
// RULE4: codes 32..62 never produced, reserved
// RULE5: invalid estimate returns all-ones code
// RULE6: polarity bits D..A at 4..1, 1=normal
// RULE7: skew bit 0 set on descrambler lock failure
// RULE8: software treats skew flag as not proof
// RULE9: MDI unswapped pair mapping per port
// RULE10: MDI-X unswapped pair mapping per port
// RULE11: swapped: ports 2/3 receive own transmit pair
// RULE12: layout valid only in link-analysis mode
// RULE13: bits 15:12 read zero; fields reset zero
`ifndef LAS_PARAMS_SVH
`define LAS_PARAMS_SVH
`define LAS_ADDR_W 5
`define LAS_DATA_W 16
`define LAS_OFS_RESULT 5'h1E
`define LAS_OFS_MODE 5'h1A
`define LAS_OFS_IRQ_STAT 5'h1B
`define LAS_OFS_IRQ_EN 5'h1C
`define LAS_OFS_IRQ_CLR 5'h1D
`define LAS_BIT_SWAP 11
`define LAS_LEN_HI 10
`define LAS_LEN_LO 5
`define LAS_POL_HI 4
`define LAS_POL_LO 1
`define LAS_BIT_SKEW 0
`define LAS_LEN_MAX_CODE 6'h1F
`define LAS_LEN_INVALID 6'h3F
`define LAS_LEN_STEP_M 5
`define LAS_RESULT_RESET 16'h0000
`define LAS_ZERO16 16'h0000
`define LAS_NUM_EVT 3
`define LAS_EVT_RESULT 0
`define LAS_EVT_SKEW 1
`define LAS_EVT_LINK 2
`define LAS_MODE_LINK 1'b1
`endif

//--- design/las_pkg.sv
// Purpose: types for the link-analysis status block
// Assumes: nothing beyond the header
// Notes: pair and link-state encodings
package las_pkg;
    typedef enum logic [1:0] {
        LAS_PAIR_A = 2'b00,
        LAS_PAIR_B = 2'b01,
        LAS_PAIR_C = 2'b10,
        LAS_PAIR_D = 2'b11
    } las_pair_type;
    typedef enum logic [1:0] {
        LAS_ST_IDLE = 2'b00,
        LAS_ST_GIG = 2'b01,
        LAS_ST_LOW = 2'b10
    } las_state_type;
endpackage

//--- design/las_len_code.sv
// Purpose: turn a raw length estimate in metres into the 6-bit code
// Assumes: estimate arrives on the core clock
// Notes: registered output
`include "las_params.svh"
module las_len_code
    import las_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // estimate
    input wire logic [8:0] len_m_i,
    input wire logic len_ok_i,
    // code
    output logic [5:0] code_o
);
    logic [8:0] steps;
    logic [5:0] code_d;
    assign steps = len_m_i / 9'(`LAS_LEN_STEP_M);
    always_comb begin
        if (!len_ok_i) begin
            code_d = `LAS_LEN_INVALID; // RULE5
        end else if (steps > 9'(`LAS_LEN_MAX_CODE)) begin
            code_d = `LAS_LEN_MAX_CODE; // RULE4
        end else begin
            code_d = steps[5:0]; // RULE3
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            code_o <= 6'h00;
        end else begin
            code_o <= code_d;
        end
    end
endmodule

//--- design/las_pair_map.sv
// Purpose: map media ports to transmit and receive pairs
// Assumes: mdix and swap are stable core-clock levels
// Notes: registered pair selects per port
`include "las_params.svh"
module las_pair_map
    import las_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // configuration
    input wire logic mdix_i,
    input wire logic swap_i,
    // per-port pair selects, port n at [2n+1:2n]
    output logic [7:0] tx_pair_o,
    output logic [7:0] rx_pair_o
);
    logic [7:0] tx_d;
    logic [7:0] rx_d;
    always_comb begin
        if (!mdix_i) begin
            tx_d = {LAS_PAIR_D, LAS_PAIR_C, LAS_PAIR_B, LAS_PAIR_A}; // RULE9
            rx_d = {LAS_PAIR_C, LAS_PAIR_D, LAS_PAIR_A, LAS_PAIR_B}; // RULE9
            if (swap_i) begin
                rx_d[7:4] = {LAS_PAIR_D, LAS_PAIR_C}; // RULE11
            end
        end else begin
            tx_d = {LAS_PAIR_C, LAS_PAIR_D, LAS_PAIR_A, LAS_PAIR_B}; // RULE10
            rx_d = {LAS_PAIR_D, LAS_PAIR_C, LAS_PAIR_B, LAS_PAIR_A}; // RULE10
            if (swap_i) begin
                rx_d[7:4] = {LAS_PAIR_C, LAS_PAIR_D}; // RULE11
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_pair_o <= 8'h00;
            rx_pair_o <= 8'h00;
        end else begin
            tx_pair_o <= tx_d;
            rx_pair_o <= rx_d;
        end
    end
endmodule

//--- verif/las_top_props.sv
// Purpose: port assertions for link-analysis status
// Assumes: mode bit mirrored from register writes
// Notes: field checks only once inputs are held still
module las_top_props (
    // clock, reset, register port
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // link status and mapping
    input wire logic link_up_i,
    input wire logic gig_i,
    input wire logic mdix_i,
    input wire logic cd_swap_det_i,
    input wire logic [3:0] pol_ok_i,
    input wire logic descr_lock_i,
    input wire logic [8:0] len_m_i,
    input wire logic len_ok_i,
    input wire logic [7:0] tx_pair_o,
    input wire logic [7:0] rx_pair_o
);
    logic mode_q;
    logic g;
    logic [5:0] code;
    logic [7:0] rx_exp;
    logic [15:0] exp_d;
    logic [15:0] exp_q;
    assign g = link_up_i & gig_i;
    assign code = !len_ok_i ? 6'h3F : (len_m_i > 9'h09F ? 6'h1F : 6'(len_m_i / 9'h005));
    assign exp_d = link_up_i ? {4'h0, g & cd_swap_det_i, code, pol_ok_i & {4{g}}, g & ~descr_lock_i} : 16'h0000;
    assign rx_exp = {(g & cd_swap_det_i) != mdix_i ? 4'hE : 4'hB, mdix_i ? 4'h4 : 4'h1};
    always_ff @(posedge mclk_i) begin
        exp_q <= exp_d;
        if (!rst_n_i) begin
            mode_q <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == 5'h1A) begin
            mode_q <= reg_wdata_i[0];
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // long enough for the deepest input-to-read path
    sequence calm_s;
        $stable({link_up_i, gig_i, mdix_i, cd_swap_det_i, pol_ok_i, descr_lock_i, len_m_i, len_ok_i, mode_q})[*7];
    endsequence
    sequence res_rd_s;
        calm_s ##0 (reg_rd_i && reg_addr_i == 5'h1E && mode_q);
    endsequence
    rsv_zero_a: assert property (reg_rdata_o[15:12] == 4'h0) else $error("upper bits set");
    len_range_a: assert property (reg_rd_i |=> !(reg_rdata_o[10:5] inside {[6'h20:6'h3E]}))
        else $error("spare length code");
    swap_bit_a: assert property (res_rd_s |=> reg_rdata_o[11] == exp_q[11]) else $error("swap bit");
    len_code_a: assert property (res_rd_s |=> reg_rdata_o[10:5] == exp_q[10:5])
        else $error("length code");
    pol_bits_a: assert property (res_rd_s |=> reg_rdata_o[4:1] == exp_q[4:1]) else $error("polarity");
    skew_flag_a: assert property (res_rd_s |=> reg_rdata_o[0] == exp_q[0]) else $error("skew flag");
    mode_gate_a: assert property (reg_rd_i && reg_addr_i == 5'h1E && !mode_q |=> reg_rdata_o == 16'h0000)
        else $error("result shown in other mode");
    tx_map_a: assert property (calm_s |-> tx_pair_o == (mdix_i ? 8'hB1 : 8'hE4)) else $error("tx map");
    rx_map_a: assert property (calm_s ##0 mode_q |-> rx_pair_o == rx_exp) else $error("rx map");
endmodule

//--- verif/las_core_model.sv
// Purpose: behavioural core and cable feeding link status
// Assumes: bench loads one whole status word at a time
// Notes: slow mode lands the word one cycle later
module las_core_model (
    // clock and request
    input wire logic mclk_i,
    input wire logic load_i,
    input wire logic slow_i,
    input wire logic [18:0] state_i,
    // link, gig, mdix, swap, pol D..A, lock, len ok, metres
    output logic [18:0] stat_o
);
    logic [18:0] pend_q;
    logic late_q;
    initial begin
        stat_o = 19'h00000;
        late_q = 1'b0;
    end
    always @(posedge mclk_i) begin
        late_q <= load_i & slow_i;
        pend_q <= load_i ? state_i : pend_q;
        if ((load_i && !slow_i) || late_q) begin
            stat_o <= late_q ? pend_q : state_i;
        end
    end
endmodule

//--- verif/test_las_top.sv
// Purpose: self-checking bench for link-analysis status
// Assumes: status settles within eight cycles of a load
// Notes: seeded random states, corner lengths first
module test_las_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, load = 1'b0, slow = 1'b0;
    logic link_up_i, gig_i, mdix_i, cd_swap_det_i, descr_lock_i, len_ok_i, irq_o;
    logic [3:0] pol_ok_i;
    logic [4:0] reg_addr_i = 5'h00;
    logic [7:0] tx_pair_o, rx_pair_o;
    logic [8:0] len_m_i;
    logic [8:0] lens [8] = '{9'h000, 9'h004, 9'h005, 9'h09A, 9'h09B, 9'h09F, 9'h0A0, 9'h1FF};
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, d;
    logic [18:0] st = 19'h00000, stat, s;
    int seed = 54, mismatches = 0, samples_checked = 0;
    assign {link_up_i, gig_i, mdix_i, cd_swap_det_i, pol_ok_i, descr_lock_i, len_ok_i, len_m_i} = stat;
    always #20 mclk_i = ~mclk_i;
    las_core_model u_las_core_model (.mclk_i(mclk_i), .load_i(load), .slow_i(slow), .state_i(st), .stat_o(stat));
    las_top u_las_top (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .link_up_i(link_up_i),
        .gig_i(gig_i), .mdix_i(mdix_i), .cd_swap_det_i(cd_swap_det_i), .pol_ok_i(pol_ok_i),
        .descr_lock_i(descr_lock_i), .len_m_i(len_m_i), .len_ok_i(len_ok_i), .tx_pair_o(tx_pair_o),
        .rx_pair_o(rx_pair_o), .irq_o(irq_o)
    );
    function automatic logic [15:0] exp_res(input logic [18:0] v);
        logic g;
        g = v[18] & v[17];
        return !v[18] ? 16'h0000 : {4'h0, g & v[15], (!v[9] ? 6'h3F : (v[8:0] > 9'h09F ? 6'h1F :
            6'(v[8:0] / 9'h005))), v[14:11] & {4{g}}, g & ~v[10]};
    endfunction
    function automatic logic [15:0] exp_map(input logic [18:0] v);
        logic [7:0] t, o;
        t = v[16] ? 8'hB1 : 8'hE4;
        o = v[16] ? 8'hE4 : 8'hB1;
        return {t, (v[18] & v[17] & v[15]) ? t[7:4] : o[7:4], o[3:0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one strobe cycle; read data land in d
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic apply(input logic [18:0] v);
        @(posedge mclk_i);
        st <= v;
        load <= 1'b1;
        @(posedge mclk_i);
        load <= 1'b0;
        repeat (8) @(posedge mclk_i);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        acc(1'b0, 5'h1E, 16'h0000);
        chk(d, 16'h0000);
        acc(1'b0, 5'h1A, 16'h0000);
        chk(d, 16'h0001);
        acc(1'b1, 5'h1E, 16'hFFFF);
        acc(1'b0, 5'h1E, 16'h0000);
        chk(d, 16'h0000);
        acc(1'b0, 5'h05, 16'h0000);
        chk(d, 16'h0000);
        for (int i = 0; i < 48; i++) begin
            s = 19'($random(seed));
            if (i < 8) begin
                s[18] = 1'b1;
                s[9] = (i != 2);
                s[8:0] = lens[i];
            end
            slow <= i[0];
            apply(s);
            acc(1'b0, 5'h1E, 16'h0000);
            // skew bit taken only as reported, no cause inferred
            chk(d, exp_res(s));
            chk({tx_pair_o, rx_pair_o}, exp_map(s));
        end
        acc(1'b1, 5'h1A, 16'h0000);
        acc(1'b0, 5'h1E, 16'h0000);
        chk(d, 16'h0000);
        acc(1'b1, 5'h1A, 16'h0001);
        apply(19'h00000);
        acc(1'b1, 5'h1C, 16'h0000);
        acc(1'b1, 5'h1D, 16'h0007);
        acc(1'b0, 5'h1B, 16'h0000);
        chk({d[14:0], irq_o}, 16'h0000);
        apply(19'h67E0A);
        acc(1'b0, 5'h1B, 16'h0000);
        chk({d[14:0], irq_o}, 16'h000A);
        acc(1'b1, 5'h1C, 16'h0002);
        acc(1'b0, 5'h1C, 16'h0000);
        chk(d, 16'h0002);
        apply(19'h67A0A);
        acc(1'b0, 5'h1B, 16'h0000);
        chk({d[14:0], irq_o}, 16'h000F);
        acc(1'b1, 5'h1D, 16'h0002);
        acc(1'b0, 5'h1B, 16'h0000);
        chk({d[14:0], irq_o}, 16'h000A);
        acc(1'b0, 5'h1D, 16'h0000);
        chk(d, 16'h0000);
        // mid-run reset with a gigabit link still up
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1 chk({tx_pair_o, rx_pair_o}, 16'h0000);
        chk({reg_rdata_o[14:0], irq_o}, 16'h0000);
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        // first read after release still sees the reset value
        acc(1'b0, 5'h1E, 16'h0000);
        chk(d, 16'h0000);
        acc(1'b0, 5'h1E, 16'h0000);
        chk(d, exp_res(19'h67A0A));
        conclude();
    end
endmodule
bind las_top las_top_props u_las_top_props (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .link_up_i(link_up_i),
    .gig_i(gig_i), .mdix_i(mdix_i), .cd_swap_det_i(cd_swap_det_i), .pol_ok_i(pol_ok_i),
    .descr_lock_i(descr_lock_i), .len_m_i(len_m_i), .len_ok_i(len_ok_i), .tx_pair_o(tx_pair_o),
    .rx_pair_o(rx_pair_o)
);
